// ---- verilog/bcm_pkg.sv ----
// constants, types and codes shared by the bus cycle break matcher
// assumes one 100 MHz clock, async active-low reset, no register bus
//
// Functional notes
// - fetch/read/cpu setting breaks before instruction, pc saved
// - break address is high half over low half
// - fetch with write only never breaks
// - odd fetch break address misses even fetches
// - odd branch fetch breaks after address error
// - cpu word write data setting breaks
// - odd word address data read never breaks
// - dma longword read data setting breaks
// - dma requester with fetch never breaks
// - paired latter fetch break survives register change
// - plain branch: two overrun fetches, then destination
// - delayed branch: slot, one overrun, destination
// - only confirmed fetches and address-error fetches cause fetch breaks
// - overrun fetch satisfies a data condition
// - higher exception in decode drops pending break
// - first non-delay branch destination fetch breaks only after address error
// - module stop halts block, access after release
// - requester, id or read/write select field 00 means no break
// - disable bit suppresses break requests
package bcm_pkg;

  // cycle type field positions
  localparam int unsigned CT_REQ_LSB = 6;
  localparam int unsigned CT_ID_LSB  = 4;
  localparam int unsigned CT_RW_LSB  = 2;
  localparam int unsigned CT_SZ_LSB  = 0;

  // two-bit select codes
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SZ_BYTE  = 2'h1;
  localparam logic [1:0] SZ_WORD  = 2'h2;
  localparam logic [1:0] SZ_LONG  = 2'h3;

  // offset of the latter instruction of a paired fetch
  localparam logic [31:0] PAIR_OFS = 32'h0000_0002;

  // reset values
  localparam logic [31:0] RST_PC = 32'h0000_0000;

  typedef struct packed {
    logic        valid;      // cycle on bus this clock
    logic        dma;        // 1: dma or transfer controller
    logic        fetch;      // 1: instruction fetch
    logic        write;      // 1: write cycle
    logic [1:0]  size;       // operand size code
    logic        pair;       // two instructions in one fetch
    logic        dest_first; // first fetch after non-delay branch
    logic [31:0] addr;       // cycle address
  } bcm_cycle_t;

  typedef struct packed {
    logic       req_cpu;
    logic       req_dma;
    logic       id_fetch;
    logic       id_data;
    logic       rw_rd;
    logic       rw_wr;
    logic [1:0] size;
    logic       none;
  } bcm_cond_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PEND = 2'b01,
    ST_AERR = 2'b10,
    ST_REQ  = 2'b11
  } bcm_st_t;

  typedef struct packed {
    bcm_st_t     st;
    logic [31:0] pc;
    logic        f_elig;
    logic        d_elig;
  } bcm_state_t;

endpackage : bcm_pkg

// ---- verilog/bcm_cond_decode.sv ----
// decodes the cycle type setting into condition flags
// assumes the setting is a static level from software
`timescale 1ns/1ps
module bcm_cond_decode (
  input  wire logic [7:0]        cycle_type_i, // break_cycle_type
  output bcm_pkg::bcm_cond_t     cond_o        // decoded flags
);
  logic [1:0] req_f;
  logic [1:0] id_f;
  logic [1:0] rw_f;

  always_comb begin
    req_f = cycle_type_i[bcm_pkg::CT_REQ_LSB +: 2];
    id_f  = cycle_type_i[bcm_pkg::CT_ID_LSB +: 2];
    rw_f  = cycle_type_i[bcm_pkg::CT_RW_LSB +: 2];
    cond_o.req_cpu  = req_f[0];
    cond_o.req_dma  = req_f[1];
    cond_o.id_fetch = id_f[0];
    cond_o.id_data  = id_f[1];
    cond_o.rw_rd    = rw_f[0];
    cond_o.rw_wr    = rw_f[1];
    cond_o.size     = cycle_type_i[bcm_pkg::CT_SZ_LSB +: 2];
    cond_o.none     = (req_f == bcm_pkg::SEL_NONE)
                    | (id_f == bcm_pkg::SEL_NONE)
                    | (rw_f == bcm_pkg::SEL_NONE);
  end
endmodule : bcm_cond_decode

// ---- verilog/bcm_addr_cmp.sv ----
// masked address compare, both halves of a paired fetch
// assumes fetch cycles carry an even address
`timescale 1ns/1ps
module bcm_addr_cmp (
  input  wire logic [15:0] addr_high_i, // break_addr_high
  input  wire logic [15:0] addr_low_i,  // break_addr_low
  input  wire logic [31:0] mask_i,      // 1: bit ignored
  input  wire logic [31:0] addr_i,      // cycle address
  input  wire logic        pair_i,      // paired fetch
  output logic             hit_o,       // address matches
  output logic [31:0]      hit_addr_o   // matching instruction
);
  logic [31:0] brk;
  logic        hit0;
  logic        hit1;

  function automatic logic eq_m(input logic [31:0] a,
                                input logic [31:0] b,
                                input logic [31:0] m);
    eq_m = ((a ^ b) & ~m) == 32'h0000_0000;
  endfunction : eq_m

  always_comb begin
    brk  = {addr_high_i, addr_low_i};
    hit0 = eq_m(addr_i, brk, mask_i);
    hit1 = pair_i & eq_m(addr_i + bcm_pkg::PAIR_OFS, brk, mask_i);
    hit_o      = hit0 | hit1;
    hit_addr_o = hit0 ? addr_i : addr_i + bcm_pkg::PAIR_OFS;
  end
endmodule : bcm_addr_cmp

// ---- verilog/bcm_matcher.sv ----
// bus cycle break matcher top
// assumes cpu reports fetch confirm or flush for each held fetch,
// and the interrupt controller acknowledges the request
`timescale 1ns/1ps
module bcm_matcher #(
  parameter int unsigned ADDR_W = 32
) (
  input  wire logic               clk_i,                  // clock
  input  wire logic               rst_n_i,                // reset
  input  wire logic               module_stop_bit_i,      // 1: standby
  input  wire logic [15:0]        break_addr_high_i,      // addr high
  input  wire logic [15:0]        break_addr_low_i,       // addr low
  input  wire logic [31:0]        break_addr_mask_i,      // 1: ignore
  input  wire logic [7:0]         break_cycle_type_i,     // cycle type
  input  wire logic               break_request_disable_i,// 1: off
  input  bcm_pkg::bcm_cycle_t     cycle_i,                // bus cycle
  input  wire logic               fetch_confirm_i,        // executes
  input  wire logic               fetch_flush_i,          // overrun
  input  wire logic               addr_err_i,             // odd fetch
  input  wire logic               addr_err_done_i,        // handled
  input  wire logic               exc_accept_i,           // higher exc
  input  wire logic               break_ack_i,            // taken
  output logic                    break_req_o,            // request
  output logic [31:0]             break_pc_o,             // saved pc
  output logic                    reg_access_ok_o,        // not stopped
  output logic                    fetch_pending_o         // fetch held
);

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  if (ADDR_W != 32) begin : g_chk
    $error("bcm_matcher serves a 32-bit address only");
  end

  // ---------------------------------------------------------------
  // decode and compare
  // ---------------------------------------------------------------
  bcm_pkg::bcm_cond_t  cond;
  bcm_pkg::bcm_state_t s_q;
  bcm_pkg::bcm_state_t s_d;
  logic                hit;
  logic [31:0]         hit_addr;

  bcm_cond_decode u_dec (
    .cycle_type_i (break_cycle_type_i),
    .cond_o       (cond)
  );

  bcm_addr_cmp u_cmp (
    .addr_high_i (break_addr_high_i),
    .addr_low_i  (break_addr_low_i),
    .mask_i      (break_addr_mask_i),
    .addr_i      (cycle_i.addr),
    .pair_i      (cycle_i.pair & cycle_i.fetch),
    .hit_o       (hit),
    .hit_addr_o  (hit_addr)
  );

  function automatic logic size_ok(input logic [1:0] want,
                                   input logic [1:0] have);
    size_ok = (want == bcm_pkg::SEL_NONE) | (want == have);
  endfunction : size_ok

  // ---------------------------------------------------------------
  // match terms
  // ---------------------------------------------------------------
  logic run;
  logic cpu_fetch;
  logic f_elig;
  logic d_elig;
  logic data_hit;
  logic fetch_seen;

  always_comb begin
    run       = ~module_stop_bit_i;
    // dma never fetches: fetch terms need cpu
    cpu_fetch = cycle_i.valid & cycle_i.fetch & ~cycle_i.dma;
    // fetch cycles are word reads
    f_elig    = cond.req_cpu & cond.id_fetch & cond.rw_rd
              & size_ok(cond.size, bcm_pkg::SZ_WORD)
              & ~cond.none;
    // overrun fetch counts as a data read
    d_elig    = cond.req_cpu & cond.id_data & cond.rw_rd
              & size_ok(cond.size, bcm_pkg::SZ_WORD)
              & ~cond.none;
    fetch_seen = cpu_fetch & hit & (f_elig | d_elig);
    data_hit  = cycle_i.valid & ~cycle_i.fetch & hit
              & ~cond.none
              & (cycle_i.dma ? cond.req_dma : cond.req_cpu)
              & cond.id_data
              & (cycle_i.write ? cond.rw_wr : cond.rw_rd)
              & size_ok(cond.size, cycle_i.size);
  end

  // ---------------------------------------------------------------
  // state update
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (run) begin
      case (s_q.st)
        bcm_pkg::ST_IDLE: begin
          if (data_hit) begin
            s_d.pc = cycle_i.addr;
            s_d.st = break_request_disable_i ? bcm_pkg::ST_IDLE
                                             : bcm_pkg::ST_REQ;
          end else if (fetch_seen && addr_err_i && f_elig) begin
            s_d.pc = hit_addr;
            s_d.st = bcm_pkg::ST_AERR;
          end else if (fetch_seen && !cycle_i.dest_first) begin
            // latch now: later setting changes do not matter
            s_d.pc     = hit_addr;
            s_d.f_elig = f_elig;
            s_d.d_elig = d_elig;
            s_d.st     = bcm_pkg::ST_PEND;
          end
        end
        bcm_pkg::ST_PEND: begin
          if (exc_accept_i) begin
            s_d.st = bcm_pkg::ST_IDLE;
          end else if (fetch_confirm_i) begin
            s_d.st = (s_q.f_elig && !break_request_disable_i)
                   ? bcm_pkg::ST_REQ : bcm_pkg::ST_IDLE;
          end else if (fetch_flush_i) begin
            // overrun after taken branch
            s_d.st = (s_q.d_elig && !break_request_disable_i)
                   ? bcm_pkg::ST_REQ : bcm_pkg::ST_IDLE;
          end
        end
        bcm_pkg::ST_AERR: begin
          if (addr_err_done_i) begin
            s_d.st = break_request_disable_i ? bcm_pkg::ST_IDLE
                                             : bcm_pkg::ST_REQ;
          end
        end
        bcm_pkg::ST_REQ: begin
          if (break_ack_i) begin
            s_d.st = bcm_pkg::ST_IDLE;
          end
        end
        default: begin
          s_d.st = bcm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q.st     <= bcm_pkg::ST_IDLE;
      s_q.pc     <= bcm_pkg::RST_PC;
      s_q.f_elig <= 1'b0;
      s_q.d_elig <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_comb begin
    break_req_o     = (s_q.st == bcm_pkg::ST_REQ)
                    & ~break_request_disable_i;
    break_pc_o      = s_q.pc;
    reg_access_ok_o = run;
    fetch_pending_o = (s_q.st == bcm_pkg::ST_PEND);
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_stop_holds: assert property (
    module_stop_bit_i |-> !reg_access_ok_o ##1 $stable(s_q))
    else $error("state moved in module standby");

  chk_disable_quiet: assert property (
    break_request_disable_i |-> !break_req_o)
    else $error("request raised while disabled");

  chk_none_quiet: assert property (
    (s_q.st == bcm_pkg::ST_IDLE) && cond.none && run
    |=> s_q.st == bcm_pkg::ST_IDLE)
    else $error("break left idle with a 00 select");

  chk_fetch_write: assert property (
    (s_q.st == bcm_pkg::ST_IDLE) && run
    && (break_cycle_type_i[5:2] == 4'h6)
    |=> s_q.st == bcm_pkg::ST_IDLE)
    else $error("fetch-write setting left idle");

  chk_dest_skip: assert property (
    (s_q.st == bcm_pkg::ST_IDLE) && run && cycle_i.valid
    && cycle_i.fetch && cycle_i.dest_first && !addr_err_i
    |=> s_q.st == bcm_pkg::ST_IDLE)
    else $error("first destination fetch broke");

  chk_confirm_pc: assert property (
    (s_q.st == bcm_pkg::ST_PEND) && run && !exc_accept_i
    && fetch_confirm_i && s_q.f_elig && !break_request_disable_i
    |=> break_req_o && (break_pc_o == $past(s_q.pc)))
    else $error("confirmed fetch did not request with its pc");

  chk_pend_latch: assert property (
    (s_q.st == bcm_pkg::ST_PEND) ##1 (s_q.st == bcm_pkg::ST_PEND)
    |-> $stable(s_q.pc) && $stable(s_q.f_elig))
    else $error("held fetch changed while pending");

  chk_flush_path: assert property (
    (s_q.st == bcm_pkg::ST_PEND) && run && !exc_accept_i
    && !fetch_confirm_i && fetch_flush_i && !s_q.d_elig
    |=> s_q.st == bcm_pkg::ST_IDLE)
    else $error("overrun fetch caused a fetch break");

  chk_flush_data: assert property (
    (s_q.st == bcm_pkg::ST_PEND) && run && !exc_accept_i
    && !fetch_confirm_i && fetch_flush_i && s_q.d_elig
    && !break_request_disable_i |=> break_req_o)
    else $error("overrun fetch missed the data break");

  chk_exc_drop: assert property (
    (s_q.st == bcm_pkg::ST_PEND) && run && exc_accept_i
    |=> s_q.st == bcm_pkg::ST_IDLE)
    else $error("pending break kept over higher exception");

  chk_aerr_wait: assert property (
    (s_q.st == bcm_pkg::ST_AERR) && !addr_err_done_i
    |=> (s_q.st == bcm_pkg::ST_AERR) && !break_req_o)
    else $error("break before address error done");

  chk_data_req: assert property (
    (s_q.st == bcm_pkg::ST_IDLE) && run && data_hit
    && !break_request_disable_i
    |=> break_req_o && (break_pc_o == $past(cycle_i.addr)))
    else $error("data hit did not request");

  chk_req_hold: assert property (
    break_req_o && !break_ack_i && run && !break_request_disable_i
    |=> break_req_o)
    else $error("request dropped without ack");

  // ---------------------------------------------------------------
  // checks on the match terms
  // ---------------------------------------------------------------
  chk_addr_concat: assert property (
    (s_q.st == bcm_pkg::ST_IDLE) && run && data_hit
    |-> (((cycle_i.addr ^ {break_addr_high_i, break_addr_low_i})
         & ~break_addr_mask_i) == 32'h0000_0000))
    else $error("data hit away from the break address");

  chk_odd_fetch: assert property (
    (s_q.st == bcm_pkg::ST_IDLE) && run && cycle_i.valid && cycle_i.fetch
    && !cycle_i.addr[0] && break_addr_low_i[0] && !break_addr_mask_i[0]
    |=> s_q.st == bcm_pkg::ST_IDLE)
    else $error("even fetch matched an odd break address");

  chk_odd_word: assert property (
    (s_q.st == bcm_pkg::ST_IDLE) && run && cycle_i.valid && !cycle_i.fetch
    && (cycle_i.size == bcm_pkg::SZ_WORD) && !cycle_i.addr[0]
    && break_addr_low_i[0] && !break_addr_mask_i[0]
    |=> s_q.st == bcm_pkg::ST_IDLE)
    else $error("even word access matched an odd break address");

  chk_dma_fetch: assert property (
    (s_q.st == bcm_pkg::ST_IDLE) && run && cycle_i.valid && cycle_i.fetch
    && cycle_i.dma |=> s_q.st == bcm_pkg::ST_IDLE)
    else $error("dma requester fetch left idle");

  chk_dma_long: assert property (
    (s_q.st == bcm_pkg::ST_IDLE) && run && cycle_i.valid && cycle_i.dma
    && !cycle_i.fetch && !cycle_i.write && (cycle_i.size == bcm_pkg::SZ_LONG)
    && hit && (break_cycle_type_i == 8'ha7) && !break_request_disable_i
    |=> break_req_o)
    else $error("dma longword read missed its break");

  chk_word_write: assert property (
    (s_q.st == bcm_pkg::ST_IDLE) && run && cycle_i.valid && !cycle_i.dma
    && !cycle_i.fetch && cycle_i.write && (cycle_i.size == bcm_pkg::SZ_WORD)
    && hit && (break_cycle_type_i == 8'h6a) && !break_request_disable_i
    |=> break_req_o)
    else $error("cpu word write missed its break");

  chk_size_miss: assert property (
    (s_q.st == bcm_pkg::ST_IDLE) && run && cycle_i.valid && !cycle_i.fetch
    && (cond.size != bcm_pkg::SEL_NONE) && (cond.size != cycle_i.size)
    |=> s_q.st == bcm_pkg::ST_IDLE)
    else $error("data break with the wrong size");

  chk_dir_miss: assert property (
    (s_q.st == bcm_pkg::ST_IDLE) && run && cycle_i.valid && !cycle_i.fetch
    && (cycle_i.write ? !break_cycle_type_i[bcm_pkg::CT_RW_LSB + 1]
                      : !break_cycle_type_i[bcm_pkg::CT_RW_LSB])
    |=> s_q.st == bcm_pkg::ST_IDLE)
    else $error("data break with the wrong direction");

  chk_pend_wait: assert property (
    (s_q.st == bcm_pkg::ST_PEND) && run && !exc_accept_i && !fetch_confirm_i
    && !fetch_flush_i |=> fetch_pending_o)
    else $error("held fetch let go without confirm or flush");

  chk_confirm_data: assert property (
    (s_q.st == bcm_pkg::ST_PEND) && run && !exc_accept_i && fetch_confirm_i
    && !s_q.f_elig |=> s_q.st == bcm_pkg::ST_IDLE)
    else $error("confirmed fetch broke on a data-only setting");

  chk_aerr_enter: assert property (
    (s_q.st == bcm_pkg::ST_IDLE) && run && fetch_seen && f_elig && addr_err_i
    |=> s_q.st == bcm_pkg::ST_AERR)
    else $error("odd destination fetch skipped the error wait");

  chk_aerr_done: assert property (
    (s_q.st == bcm_pkg::ST_AERR) && run && addr_err_done_i && !break_request_disable_i
    |=> break_req_o && (break_pc_o == $past(s_q.pc)))
    else $error("no request after address error done");

  chk_pair_pc: assert property (
    (s_q.st == bcm_pkg::ST_IDLE) && run && fetch_seen && cycle_i.pair
    && !cycle_i.dest_first && !addr_err_i
    |=> fetch_pending_o && ((break_pc_o == $past(cycle_i.addr))
        || (break_pc_o == $past(cycle_i.addr) + bcm_pkg::PAIR_OFS)))
    else $error("paired fetch held a wrong address");

  chk_pc_hold: assert property (
    (s_q.st != bcm_pkg::ST_IDLE) |=> $stable(break_pc_o))
    else $error("saved pc moved outside idle");

  chk_stop_quiet: assert property (
    module_stop_bit_i && (s_q.st != bcm_pkg::ST_REQ) |=> !break_req_o)
    else $error("request raised in module standby");

  chk_ack_clear: assert property (
    (s_q.st == bcm_pkg::ST_REQ) && run && break_ack_i
    |=> (s_q.st == bcm_pkg::ST_IDLE) && !break_req_o)
    else $error("request kept after ack");

  cov_fetch_brk: cover property (
    (s_q.st == bcm_pkg::ST_PEND) ##1 break_req_o);
  cov_data_brk: cover property (
    data_hit && run ##1 break_req_o);
  cov_aerr_brk: cover property (
    (s_q.st == bcm_pkg::ST_AERR) ##1 break_req_o);
  cov_exc_drop: cover property (
    (s_q.st == bcm_pkg::ST_PEND) && exc_accept_i);
  cov_flush_brk: cover property (
    (s_q.st == bcm_pkg::ST_PEND) && fetch_flush_i ##1 break_req_o);

endmodule : bcm_matcher

// ---- tb/bcm_irq_partner.sv ----
// behavioural interrupt controller that takes the break request
// assumes requests arrive as a level and ack is sampled on posedge
`timescale 1ns/1ps
module bcm_irq_partner (
  input  wire logic       clk_i,       // clock
  input  wire logic       rst_n_i,     // async reset, active low
  input  wire logic       break_req_i, // request from matcher
  input  wire logic [3:0] ack_delay_i, // cycles before acking
  output logic            break_ack_o  // one-cycle acknowledge
);
  logic [3:0] wait_q;

  // ----------------------------------------------------------------
  // acknowledge after a programmable wait
  // ----------------------------------------------------------------
  // changes only at the falling edge, so the pulse holds over a posedge
  always @(negedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q      <= 4'h0;
      break_ack_o <= 1'b0;
    end else if (break_req_i && !break_ack_o) begin
      if (wait_q >= ack_delay_i) begin
        break_ack_o <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end else begin
      break_ack_o <= 1'b0;
      wait_q      <= 4'h0;
    end
  end
endmodule : bcm_irq_partner

// ---- tb/bcm_matcher_test.sv ----
// self-checking testbench for the bus cycle break matcher
// assumes bcm_pkg and the design files are compiled before it
`timescale 1ns/1ps
module bcm_matcher_test;
  logic                clk, rst_n, stop, dis, ack;
  logic                confirm, flush, aerr, aerr_done, exc;
  logic [15:0]         addr_hi, addr_lo;
  logic [31:0]         mask;
  logic [7:0]          ctype;
  logic [3:0]          ack_dly;
  bcm_pkg::bcm_cycle_t cyc;
  logic                break_req_o, reg_access_ok_o, fetch_pending_o;
  logic [31:0]         break_pc_o;
  int                  fails, checks_done;
  logic [7:0]          bad [3] = '{8'h26, 8'h46, 8'h62};

  bcm_matcher i_dut (.clk_i(clk), .rst_n_i(rst_n), .module_stop_bit_i(stop),
    .break_addr_high_i(addr_hi), .break_addr_low_i(addr_lo), .break_addr_mask_i(mask),
    .break_cycle_type_i(ctype), .break_request_disable_i(dis), .cycle_i(cyc),
    .fetch_confirm_i(confirm), .fetch_flush_i(flush), .addr_err_i(aerr),
    .addr_err_done_i(aerr_done), .exc_accept_i(exc), .break_ack_i(ack),
    .break_req_o(break_req_o), .break_pc_o(break_pc_o),
    .reg_access_ok_o(reg_access_ok_o), .fetch_pending_o(fetch_pending_o));

  bcm_irq_partner i_irq (.clk_i(clk), .rst_n_i(rst_n), .break_req_i(break_req_o),
    .ack_delay_i(ack_dly), .break_ack_o(ack));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic ok, input string what);
    checks_done++;
    if (!ok) begin
      fails++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : check

  function automatic bcm_pkg::bcm_cycle_t mk(input logic d, f, w, input logic [1:0] s,
                                              input logic p, df, input logic [31:0] a);
    mk = '{valid: 1'b1, dma: d, fetch: f, write: w, size: s, pair: p, dest_first: df,
           addr: a};
  endfunction : mk

  // post: 0 none, 1 confirm, 2 flush, 3 higher exception, 4 address error done
  task automatic run(input string name, input logic [7:0] ct, input logic [31:0] ba,
                     input bcm_pkg::bcm_cycle_t c, input int post, input logic ae,
                     input logic chg, input logic exp, input logic [31:0] pc);
    int n;
    ctype   = ct;
    addr_hi = ba[31:16];
    addr_lo = ba[15:0];
    cyc     = c;
    aerr    = ae;
    @(negedge clk);
    cyc.valid = 1'b0;
    aerr      = 1'b0;
    if (post > 0 && post < 4 && (exp || post > 1))
      check(fetch_pending_o === 1'b1, "fetch not held");
    if (chg) addr_lo = ~addr_lo;
    if (chg) @(negedge clk);
    if (post == 4) begin
      repeat (3) @(negedge clk);
      check(break_req_o === 1'b0, "request before address error done");
    end
    if (post != 0) begin
      {confirm, flush, exc, aerr_done} = {post == 1, post == 2, post == 3, post == 4};
      @(negedge clk);
      {confirm, flush, exc, aerr_done} = 4'h0;
    end
    check(break_req_o === exp, "request level");
    if (exp) begin
      check(break_pc_o === pc, "saved pc");
      n = 0;
      while (break_req_o !== 1'b0 && n < 20) begin
        @(negedge clk);
        n++;
      end
      check(n < 20, "request not released");
    end else begin
      repeat (3) begin
        @(negedge clk);
        check(break_req_o === 1'b0, "spurious request");
      end
      check(fetch_pending_o === 1'b0, "fetch still held");
    end
    @(negedge clk);
    $display("test %s done", name);
  endtask : run

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100000;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end

  initial begin
    {rst_n, stop, dis, confirm, flush, aerr, aerr_done, exc} = 8'h00;
    {addr_hi, addr_lo, mask, ctype, ack_dly} = 76'h0;
    cyc     = '0;
    {fails, checks_done} = 64'h0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check(break_req_o === 1'b0 && break_pc_o === 32'h0 && fetch_pending_o === 1'b0, "reset");
    check(reg_access_ok_o === 1'b1, "access after reset");
    run("fetch", 8'h54, 32'h0000_0404, mk(0, 1, 0, 2'h2, 0, 0, 32'h0000_0404), 1, 0, 0, 1,
        32'h0000_0404);
    run("fetch write", 8'h58, 32'h0015_389c, mk(0, 1, 0, 2'h2, 0, 0, 32'h0015_389c), 1, 0, 0,
        0, 0);
    run("odd fetch", 8'h54, 32'h0003_0147, mk(0, 1, 0, 2'h2, 1, 0, 32'h0003_0146), 1, 0, 0,
        0, 0);
    ack_dly = 4'h3;
    run("addr error", 8'h54, 32'h0003_0147, mk(0, 1, 0, 2'h2, 0, 1, 32'h0003_0147), 4, 1, 0,
        1, 32'h0003_0147);
    run("word write", 8'h6a, 32'h0012_3456, mk(0, 0, 1, 2'h2, 0, 0, 32'h0012_3456), 0, 0, 0,
        1, 32'h0012_3456);
    run("odd word", 8'h66, 32'h00a8_0391, mk(0, 0, 0, 2'h2, 0, 0, 32'h00a8_0390), 0, 0, 0, 0,
        0);
    ack_dly = 4'h0;
    run("dma long", 8'ha7, 32'h0076_bcdc, mk(1, 0, 0, 2'h3, 0, 0, 32'h0076_bcdc), 0, 0, 0, 1,
        32'h0076_bcdc);
    run("dma fetch", 8'h94, 32'h0023_45c8, mk(1, 1, 0, 2'h2, 0, 0, 32'h0023_45c8), 1, 0, 0, 0,
        0);
    run("paired", 8'h54, 32'h0000_0406, mk(0, 1, 0, 2'h2, 1, 0, 32'h0000_0404), 1, 0, 1, 1,
        32'h0000_0406);
    run("overrun", 8'h54, 32'h0000_0408, mk(0, 1, 0, 2'h2, 0, 0, 32'h0000_0408), 2, 0, 0, 0,
        0);
    run("overrun data", 8'h74, 32'h0000_0408, mk(0, 1, 0, 2'h2, 0, 0, 32'h0000_0408), 2, 0, 0,
        1, 32'h0000_0408);
    run("confirm data", 8'h64, 32'h0000_0408, mk(0, 1, 0, 2'h2, 0, 0, 32'h0000_0408), 1, 0, 0,
        0, 0);
    run("exception", 8'h54, 32'h0000_0500, mk(0, 1, 0, 2'h2, 0, 0, 32'h0000_0500), 3, 0, 0, 0,
        0);
    run("dest first", 8'h54, 32'h0000_0600, mk(0, 1, 0, 2'h2, 0, 1, 32'h0000_0600), 1, 0, 0,
        0, 0);
    dis = 1'b1;
    run("disabled", 8'h6a, 32'h0012_3456, mk(0, 0, 1, 2'h2, 0, 0, 32'h0012_3456), 0, 0, 0, 0,
        0);
    dis  = 1'b0;
    mask = 32'h0000_000f;
    run("masked", 8'h6a, 32'h0012_3450, mk(0, 0, 1, 2'h2, 0, 0, 32'h0012_3456), 0, 0, 0, 1,
        32'h0012_3456);
    run("size miss", 8'h69, 32'h0012_3450, mk(0, 0, 1, 2'h2, 0, 0, 32'h0012_3456), 0, 0, 0,
        0, 0);
    mask = 32'h0000_0000;
    run("both req", 8'he6, 32'h0012_3456, mk(1, 0, 0, 2'h2, 0, 0, 32'h0012_3456), 0, 0, 0, 1,
        32'h0012_3456);
    foreach (bad[i])
      run("no field", bad[i], 32'h0012_3456, mk(0, 0, 0, 2'h2, 0, 0, 32'h0012_3456), 0, 0, 0,
          0, 0);
    stop = 1'b1;
    @(negedge clk);
    check(reg_access_ok_o === 1'b0, "access in standby");
    run("standby", 8'h6a, 32'h0012_3456, mk(0, 0, 1, 2'h2, 0, 0, 32'h0012_3456), 0, 0, 0, 0,
        0);
    stop = 1'b0;
    @(negedge clk);
    check(reg_access_ok_o === 1'b1 && break_req_o === 1'b0, "standby release");
    results();
  end
endmodule : bcm_matcher_test
